//--- eint_front.sv
// Purpose: pin front end of the interrupt unit with an AXI4-Lite register port
// Assumes: pins asynchronous, one clock clk_sys at 40 MHz, synchronous reset
// Notes:   nmi beats all maskable sources, has no mask bit and only a read-only status bit
// Function
// - synchronise requests; edge or level per input
// - unmasked request vectors to its own entry
// - request 0 cascade turns pin 2 into ack 0
// - request 1 cascade turns pin 3 into ack 1
// - slave mode drives request to external master
// - demod feeds timer0/req2 true, timer1/req4 inverted
// - demod mode ignores timer and request 4 pins
// - request 4 flags demod falling edge
// - pin 2 level mirrored into gpio bit 31
// - nmi highest, unmaskable, own vector
// - nmi has only a read-only status bit, no priority share
// - any taken interrupt clears interrupt-enable flag, except when a control write lands in the same cycle
// - nmi rising edge latched, taken at boundary
`timescale 1ns/1ps
module eint_front
   import eint_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // axi4-lite write address and data
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // axi4-lite write response
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // axi4-lite read
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [3:0]  s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // request pins
   input  wire logic        maskable_req_0,
   input  wire logic        maskable_req_1,
   input  wire logic        maskable_req_2,
   input  wire logic        maskable_req_3,
   input  wire logic        maskable_req_4,
   input  wire logic        nmi_in,
   input  wire logic        timer_input_0,
   input  wire logic        timer_input_1,
   // shared pin outputs, enable low while driving
   output logic             cascade_ack_0,
   output logic             cascade_ack_0_oe_n,
   output logic             pin3_out,
   output logic             pin3_oe_n,
   // cascade type from the peripheral
   input  wire logic [7:0]  cascade_type,
   // processor side
   input  wire logic        instr_boundary,
   output logic             take,
   output logic [7:0]       take_vector,
   output logic             select_seen,
   // timer feeds and gpio mirror
   output logic             timer_feed_0,
   output logic             timer_feed_1,
   output logic             gpio_bit_31,
   // interrupt line
   output logic             irq
);
   import eint_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // byte-lane merge, used by every writable register
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) m[i*8 +: 8] = nw[i*8 +: 8];
      end
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // synchroniser on every pin
   eint_sync_if sif ();
   assign sif.raw = {timer_input_1, timer_input_0, nmi_in, maskable_req_4,
                     maskable_req_3, maskable_req_2, maskable_req_1, maskable_req_0};
   eint_sync u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .sif     (sif)
   );
   // state
   logic [CTRL_W-1:0] ctrl_r;      // configuration
   logic [NREQ-1:0]   mask_r;      // one = source enabled
   logic [NREQ-1:0]   status_r;    // sticky pending bits
   logic [NLANE-1:0]  prev_r;      // last synchronised levels
   logic              nmi_pend_r;  // latched nmi edge
   logic              iflag_r;     // processor interrupt-enable flag
   logic [7:0]        taken_r;     // last vector taken
   logic              aw_got_r;
   logic              w_got_r;
   logic [3:0]        aw_addr_r;
   logic [31:0]       w_data_r;
   logic [3:0]        w_strb_r;
   ////////////////////////////////////////////////////////////////////////
   // mode decode
   wire casc0 = ctrl_r[CTRL_CASC0];
   wire casc1 = ctrl_r[CTRL_CASC1];
   wire slave = ctrl_r[CTRL_SLAVE];
   wire demod = ctrl_r[CTRL_DEMOD];
   wire [NREQ-1:0] lvl_mode = ctrl_r[CTRL_LEVEL_LSB +: NREQ];
   wire demod_lvl = sif.level[2];   // pin 2 doubles as demodulator input
   // source levels after pin muxing
   logic [NREQ-1:0] src;
   logic [NREQ-1:0] src_prev;
   always_comb begin
      src      = sif.level[NREQ-1:0];
      src_prev = prev_r[NREQ-1:0];
      if (slave) begin
         src[1]      = 1'b0;                // pin 1 is the select input
         src_prev[1] = 1'b0;
      end
      if (casc0) begin
         src[2]      = 1'b0;
         src_prev[2] = 1'b0;
      end
      if (casc1 || slave) begin
         src[3]      = 1'b0;
         src_prev[3] = 1'b0;
      end
      if (demod) begin
         src[4]      = ~demod_lvl;
         src_prev[4] = ~prev_r[2];
      end
   end
   // per-source event: level while high, or rising edge
   logic [NREQ-1:0] ev;
   genvar g;
   generate
      for (g = 0; g < NREQ; g++) begin : g_ev
         // demod forces request 4 to edge so it marks each falling edge once
         wire use_lvl = lvl_mode[g] && !(demod && g == 4);
         assign ev[g] = use_lvl ? src[g] : (src[g] && !src_prev[g]);
      end
   endgenerate
   wire nmi_edge = sif.level[LN_NMI] && !prev_r[LN_NMI];
   ////////////////////////////////////////////////////////////////////////
   // priority: nmi first, then lowest request index among enabled pending
   wire [NREQ-1:0] armed = status_r & mask_r;
   logic [2:0] pick;
   always_comb begin
      pick = 3'h0;
      for (int i = NREQ - 1; i >= 0; i--) begin
         if (armed[i]) begin
            pick = 3'(i);
         end
      end
   end
   wire take_nmi = instr_boundary && nmi_pend_r;
   wire take_msk = instr_boundary && !nmi_pend_r && iflag_r && |armed;
   wire take_any = take_nmi || take_msk;
   wire casc_take = take_msk && ((pick == 3'h0 && casc0) || (pick == 3'h1 && casc1));
   wire [7:0] vec_nxt = take_nmi ? VEC_NMI :
                        casc_take ? cascade_type : (VEC_REQ0 + 8'(pick));
   wire [NREQ-1:0] ack_clr = take_msk ? (NREQ'(1) << pick) : '0;

   ////////////////////////////////////////////////////////////////////////
   // register bus decode
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take  = s_axi_wvalid && s_axi_wready;
   wire [3:0]  wa = aw_take ? s_axi_awaddr : aw_addr_r;
   wire [31:0] wd = w_take ? s_axi_wdata : w_data_r;
   wire [3:0]  ws = w_take ? s_axi_wstrb : w_strb_r;
   wire wr_go  = (aw_got_r || aw_take) && (w_got_r || w_take) && !s_axi_bvalid;
   wire wr_map = wa == OFS_CTRL || wa == OFS_STATUS || wa == OFS_MASK || wa == OFS_TAKEN;
   wire [31:0] ctrl_m  = merge(32'(ctrl_r), wd, ws);
   wire [31:0] mask_m  = merge(32'(mask_r), wd, ws);
   wire [31:0] w1c     = merge(32'h0000_0000, wd, ws);
   wire wr_ctrl   = wr_go && wa == OFS_CTRL;
   wire wr_status = wr_go && wa == OFS_STATUS;
   wire wr_mask   = wr_go && wa == OFS_MASK;

   // read mux
   wire ar_take = s_axi_arvalid && s_axi_arready;
   logic [31:0] rd_val;
   logic        rd_ok;
   always_comb begin
      rd_ok  = 1'b1;
      rd_val = 32'h0000_0000;
      unique case (s_axi_araddr)
         OFS_CTRL:   rd_val = 32'({iflag_r, ctrl_r[CTRL_W-2:0]});
         OFS_STATUS: rd_val = 32'({nmi_pend_r, status_r});
         OFS_MASK:   rd_val = 32'(mask_r);
         OFS_TAKEN:  rd_val = 32'(taken_r);
         default:    rd_ok  = 1'b0;        // unmapped answers slverr
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // status, nmi latch and interrupt-enable flag
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         status_r   <= '0;
         nmi_pend_r <= 1'b0;
         iflag_r    <= 1'b0;
         prev_r     <= '0;
         taken_r    <= 8'h00;
      end else begin
         prev_r <= sif.level;
         // set wins over both the bus clear and the acknowledge
         status_r <= (status_r & ~(wr_status ? w1c[NREQ-1:0] : '0) & ~ack_clr) | ev;
         // a fresh edge while the old one is taken keeps nmi pending
         nmi_pend_r <= nmi_edge || (nmi_pend_r && !take_nmi);
         if (wr_ctrl) begin
            iflag_r <= ctrl_m[CTRL_IFLAG];     // software sets it again
         end else if (take_any) begin
            iflag_r <= 1'b0;
         end
         taken_r <= take_any ? vec_nxt : taken_r;
      end
   end

   // configuration registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl_r <= CTRL_RST;
         mask_r <= MASK_RST;
      end else begin
         ctrl_r <= wr_ctrl ? ctrl_m[CTRL_W-1:0] : ctrl_r;
         mask_r <= wr_mask ? mask_m[NREQ-1:0] : mask_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // write channel: address and data in either order, response after both
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         aw_got_r      <= 1'b0;
         w_got_r       <= 1'b0;
         aw_addr_r     <= 4'h0;
         w_data_r      <= 32'h0000_0000;
         w_strb_r      <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         aw_addr_r <= aw_take ? s_axi_awaddr : aw_addr_r;
         w_data_r  <= w_take ? s_axi_wdata : w_data_r;
         w_strb_r  <= w_take ? s_axi_wstrb : w_strb_r;
         if (wr_go) begin
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b1;
            s_axi_bresp   <= wr_map ? RESP_OKAY : RESP_SLVERR;
         end else begin
            if (aw_take) begin
               aw_got_r      <= 1'b1;
               s_axi_awready <= 1'b0;
            end
            if (w_take) begin
               w_got_r      <= 1'b1;
               s_axi_wready <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
               s_axi_bvalid  <= 1'b0;
               s_axi_awready <= 1'b1;
               s_axi_wready  <= 1'b1;
            end
         end
      end
   end

   // read channel: one cycle from address to data
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (ar_take) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_val;
         s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin outputs, processor strobes, timer feeds, interrupt line
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cascade_ack_0      <= 1'b0;
         cascade_ack_0_oe_n <= 1'b1;
         pin3_out           <= 1'b0;
         pin3_oe_n          <= 1'b1;
         take               <= 1'b0;
         take_vector        <= 8'h00;
         select_seen        <= 1'b0;
         timer_feed_0       <= 1'b0;
         timer_feed_1       <= 1'b0;
         gpio_bit_31        <= 1'b0;
         irq                <= 1'b0;
      end else begin
         cascade_ack_0      <= casc_take && pick == 3'h0;
         cascade_ack_0_oe_n <= !casc0;
         // slave request beats the cascade ack when both are set
         pin3_out  <= slave ? (iflag_r && |armed) : (casc_take && pick == 3'h1);
         pin3_oe_n <= !(casc1 || slave);
         take        <= take_any;
         take_vector <= take_any ? vec_nxt : take_vector;
         // select only counts once request 0 is already pending
         select_seen <= slave && sif.level[1] && status_r[0];
         timer_feed_0 <= demod ? demod_lvl : sif.level[LN_TMR0];
         timer_feed_1 <= demod ? ~demod_lvl : sif.level[LN_TMR1];
         gpio_bit_31  <= demod_lvl;
         irq          <= |armed;
      end
   end
endmodule

//--- eint_pkg.sv
// Purpose: shared constants for the external interrupt front end
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes:   offsets, field positions, reset values and vector codes live here
package eint_pkg;
   // register byte offsets
   localparam logic [3:0] OFS_CTRL   = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_MASK   = 4'h8;
   localparam logic [3:0] OFS_TAKEN  = 4'hC;

   // number of maskable request lines
   localparam int unsigned NREQ = 5;

   // control field positions
   localparam int unsigned CTRL_LEVEL_LSB = 0;   // [4:0] one = level, zero = edge
   localparam int unsigned CTRL_CASC0     = 8;   // request 0 cascade
   localparam int unsigned CTRL_CASC1     = 9;   // request 1 cascade
   localparam int unsigned CTRL_SLAVE     = 10;  // slave to external master
   localparam int unsigned CTRL_DEMOD     = 11;  // pulse width demodulation
   localparam int unsigned CTRL_IFLAG     = 12;  // processor interrupt-enable flag
   localparam int unsigned CTRL_W         = 13;

   // status field positions
   localparam int unsigned STAT_NMI = 5;          // nmi pending, read only

   // reset values
   localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;
   localparam logic [NREQ-1:0]   MASK_RST = 5'h00;

   // synchroniser lane positions
   localparam int unsigned LN_NMI  = 5;
   localparam int unsigned LN_TMR0 = 6;
   localparam int unsigned LN_TMR1 = 7;
   localparam int unsigned NLANE   = 8;

   // vector table entry codes, arbitrary defaults
   localparam logic [7:0] VEC_NMI  = 8'h02;
   localparam logic [7:0] VEC_REQ0 = 8'h0C;

   // bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- eint_sync_if.sv
// Purpose: carries raw pin levels into the synchroniser and clean levels out
// Assumes: single clock domain on the synchroniser side
// Notes:   width fixed at the lane count of the package
`timescale 1ns/1ps
interface eint_sync_if;
   import eint_pkg::*;
   logic [NLANE-1:0] raw;     // pin levels, asynchronous
   logic [NLANE-1:0] level;   // synchronised levels
   modport user (output raw, input level);
   modport sync (input raw, output level);
endinterface

//--- eint_sync.sv
// Purpose: two-stage synchroniser for every asynchronous request lane
// Assumes: lanes are independent levels
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module eint_sync
   import eint_pkg::*;
(
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // lanes
   eint_sync_if.sync sif
);
   logic [NLANE-1:0] meta_r;   // first stage, may go metastable
   logic [NLANE-1:0] safe_r;   // second stage, safe to use

   ////////////////////////////////////////////////////////////////////////
   // two flip-flops per lane
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         meta_r <= '0;
         safe_r <= '0;
      end else begin
         meta_r <= sif.raw;
         safe_r <= meta_r;
      end
   end

   assign sif.level = safe_r;
endmodule

//--- eint_front_checker.sv
// Purpose: port assertions for the interrupt front end
// Assumes: one clock clk_sys, synchronous active-high rst
// Notes:   bound onto eint_front from the bench top
`timescale 1ns/1ps
module eint_front_checker (
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        rst,
   // register bus answers
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // interrupt side
   input wire logic        take,
   input wire logic [7:0]  take_vector,
   input wire logic        instr_boundary,
   input wire logic        maskable_req_2,
   input wire logic        gpio_bit_31,
   input wire logic        cascade_ack_0,
   input wire logic        cascade_ack_0_oe_n
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////
   // cycles since reset, so that no check looks back into reset-era values
   logic [2:0] up_r;
   always_ff @(posedge clk_sys) begin
      if (rst)
         up_r <= 3'h0;
      else if (up_r != 3'h7)
         up_r <= up_r + 3'h1;
   end
   ////////////////////////////////////////////////////////////////////////////
   a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
   a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped early");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && !s_axi_arready) else $error("read answer late");
   a_take_pulse: assert property (take |=> !take)
      else $error("take longer than one cycle");
   a_take_boundary: assert property (take |-> $past(instr_boundary))
      else $error("take away from a boundary");
   a_vector_held: assert property (up_r != 3'h0 && !take |-> $stable(take_vector))
      else $error("vector moved without take");
   a_ack_driven: assert property (cascade_ack_0 |-> !cascade_ack_0_oe_n)
      else $error("ack pulse on undriven pin");
   a_ack_pulse: assert property (cascade_ack_0 |=> !cascade_ack_0)
      else $error("ack longer than one cycle");
   a_pin_mirror: assert property (up_r == 3'h7 && $stable(maskable_req_2)
      && maskable_req_2 == $past(maskable_req_2, 2) && maskable_req_2 == $past(maskable_req_2, 3)
      |-> gpio_bit_31 == maskable_req_2) else $error("gpio mirror wrong");
   // main scenarios reached
   c_take: cover property (take);
   c_ack: cover property (cascade_ack_0);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

//--- eint_peripheral.sv
// Purpose: requesting peripheral that answers an acknowledge with its type
// Assumes: bench pulses fire to request and drop to give up
// Notes:   type lines toggle when not driven, so a stale value never passes
`timescale 1ns/1ps
module eint_peripheral #(
   parameter logic [7:0] TYPE_CODE = 8'h5A  // arbitrary type code
) (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // bench controls
   input  wire logic       fire,
   input  wire logic       drop,
   // device side
   input  wire logic       ack,
   output logic            req,
   output logic [7:0]      type_code
);
   logic phase_r;  // idle pattern source
   // request held until acknowledged or abandoned
   always_ff @(posedge clk_sys) begin
      if (rst || ack || drop)
         req <= 1'b0;
      else if (fire)
         req <= 1'b1;
   end
   always_ff @(posedge clk_sys) phase_r <= rst ? 1'b0 : ~phase_r;
   // type driven while requesting and through the acknowledge
   assign type_code = (req || ack) ? TYPE_CODE : {8{phase_r}};
endmodule

//--- eint_front_tb_top.sv
// Purpose: self-checking bench for the interrupt front end
// Assumes: 40 MHz clk_sys, reset held 8 cycles
// Notes:   two peripheral models drive request lines 0 and 1
`timescale 1ns/1ps
module eint_front_tb_top;
   import eint_pkg::*;
   logic        clk_sys, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, nmi_in, timer_input_0, timer_input_1;
   logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic        maskable_req_0, maskable_req_1, maskable_req_2, maskable_req_3, maskable_req_4;
   logic        cascade_ack_0, cascade_ack_0_oe_n, pin3_out, pin3_oe_n;
   logic [7:0]  cascade_type, take_vector, type_0, type_1;
   logic        instr_boundary, take, select_seen, irq, timer_feed_0, timer_feed_1;
   logic        gpio_bit_31, fire_0, fire_1, drop_0, drop_1, casc1_on;
   int          n_mismatch, n_tests, n_take;
   ////////////////////////////////////////////////////////////////////////////
   eint_front eint_front_inst (.*);
   // peripheral on request 0 and one on request 1, acked on pin 3 only in cascade
   eint_peripheral #(.TYPE_CODE(8'h5A)) eint_peripheral_inst (.clk_sys(clk_sys), .rst(rst),
      .fire(fire_0), .drop(drop_0), .ack(cascade_ack_0), .req(maskable_req_0), .type_code(type_0));
   eint_peripheral #(.TYPE_CODE(8'hA5)) eint_peripheral_inst_1 (.clk_sys(clk_sys), .rst(rst),
      .fire(fire_1), .drop(drop_1), .ack(pin3_out & ~pin3_oe_n & casc1_on),
      .req(maskable_req_1), .type_code(type_1));
   assign cascade_type = casc1_on ? type_1 : type_0;
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) if (take === 1'b1) n_take++;
   // watchdog: the whole sequence needs a few hundred cycles
   initial begin
      #200000;
      n_mismatch++;
      tally_and_finish;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // write: address and data offered together, each released once taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk_sys);
         if (s_axi_awready === 1'b1 && s_axi_awvalid === 1'b1) aw_ok = 1'b1;
         if (s_axi_wready === 1'b1 && s_axi_wvalid === 1'b1) w_ok = 1'b1;
         s_axi_awvalid <= !aw_ok;
         s_axi_wvalid <= !w_ok;
      end
      do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
      rdat = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // waits a bounded time for one take, then judges its vector
   task automatic wait_take(input logic [7:0] exp);
      int k;
      k = n_take;
      for (int i = 0; i < 40 && n_take == k; i++) @(posedge clk_sys);
      check(n_take != k, 1'b1);
      check(take_vector, exp);
   endtask
   task automatic fire(input bit which);
      if (which) fire_1 <= 1'b1;
      else fire_0 <= 1'b1;
      tick(1);
      fire_0 <= 1'b0;
      fire_1 <= 1'b0;
   endtask
   task automatic release_all;
      drop_0 <= 1'b1;
      drop_1 <= 1'b1;
      tick(1);
      drop_0 <= 1'b0;
      drop_1 <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // reset values, a byte strobe that misses the mask, an unmapped offset
   task automatic t_reset;
      rd_reg(OFS_CTRL);
      check(rdat[12:0], CTRL_RST);
      s_axi_wstrb <= 4'h2;
      wr(OFS_MASK, 32'h1F);
      check(rsp, RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      rd_reg(OFS_MASK);
      check(rdat[4:0], MASK_RST);
      rd_reg(4'h2);
      check(rsp, RESP_SLVERR);
   endtask
   // two edge requests at once: lowest index first, flag blocks the second
   task automatic t_priority;
      int k;
      wr(OFS_MASK, 32'h0A);
      maskable_req_3 <= 1'b1;
      fire(1'b1);
      tick(6);
      rd_reg(OFS_STATUS);
      check(rdat[4:0], 5'h0A);
      check(irq, 1'b1);
      wr(OFS_CTRL, 32'h1000);
      wait_take(VEC_REQ0 + 8'h1);
      k = n_take;
      rd_reg(OFS_CTRL);
      check(rdat[CTRL_IFLAG], 1'b0);
      tick(8);
      check(n_take, k);
      release_all;
      wr(OFS_CTRL, 32'h1000);
      wait_take(VEC_REQ0 + 8'h3);
      rd_reg(OFS_STATUS);
      check(rdat[4:0], 5'h00);
      maskable_req_3 <= 1'b0;
   endtask
   // level mode re-sets while the pin stays high; mask keeps irq low
   task automatic t_level;
      wr(OFS_MASK, 32'h0);
      wr(OFS_CTRL, 32'h8);
      maskable_req_3 <= 1'b1;
      tick(6);
      wr(OFS_STATUS, 32'h8);
      rd_reg(OFS_STATUS);
      check(rdat[3], 1'b1);
      check(irq, 1'b0);
      maskable_req_3 <= 1'b0;
      tick(4);
      wr(OFS_STATUS, 32'h1F);
      tick(3);
      check(irq, 1'b0);
   endtask
   // nmi twice, flag clear and mask empty, each taken at a boundary
   task automatic t_nmi;
      repeat (2) begin
         instr_boundary <= 1'b0;
         nmi_in <= 1'b1;
         tick(2);
         nmi_in <= 1'b0;
         tick(6);
         rd_reg(OFS_STATUS);
         check(rdat[5:0], 6'h20);
         instr_boundary <= 1'b1;
         wait_take(VEC_NMI);
      end
      rd_reg(OFS_TAKEN);
      check(rdat[7:0], VEC_NMI);
   endtask
   // both cascade modes: pin turned to ack, type taken from the peripheral
   task automatic t_cascade;
      wr(OFS_MASK, 32'h3);
      wr(OFS_CTRL, 32'h1100);
      tick(2);
      check(cascade_ack_0_oe_n, 1'b0);
      fire(1'b0);
      wait_take(8'h5A);
      tick(3);
      check(maskable_req_0, 1'b0);
      casc1_on <= 1'b1;
      wr(OFS_CTRL, 32'h1200);
      tick(2);
      check(pin3_oe_n, 1'b0);
      fire(1'b1);
      wait_take(8'hA5);
      tick(3);
      check(maskable_req_1, 1'b0);
      casc1_on <= 1'b0;
   endtask
   // slave: request out on pin 3, then select after request 0
   task automatic t_slave;
      instr_boundary <= 1'b0;
      wr(OFS_CTRL, 32'h1400);
      fire(1'b0);
      tick(6);
      check({pin3_out, pin3_oe_n}, 2'b10);
      fire(1'b1);
      tick(6);
      check(select_seen, 1'b1);
      release_all;
      wr(OFS_CTRL, 32'h0);
      wr(OFS_STATUS, 32'h1F);
      instr_boundary <= 1'b1;
   endtask
   // demodulator routing, ignored pins, falling edge on request 4, mirror
   task automatic t_demod;
      wr(OFS_CTRL, 32'h0800);
      wr(OFS_STATUS, 32'h1F);
      maskable_req_2 <= 1'b1;
      maskable_req_4 <= 1'b1;
      timer_input_1 <= 1'b1;
      tick(6);
      check({timer_feed_0, timer_feed_1, gpio_bit_31}, 3'b101);
      rd_reg(OFS_STATUS);
      check(rdat[4:0], 5'h04);
      maskable_req_2 <= 1'b0;
      tick(6);
      check({timer_feed_0, timer_feed_1, gpio_bit_31}, 3'b010);
      rd_reg(OFS_STATUS);
      check(rdat[4:0], 5'h14);
   endtask
   task automatic tally_and_finish;
      if (n_mismatch == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      {maskable_req_2, maskable_req_3, maskable_req_4, nmi_in, timer_input_0} = '0;
      {timer_input_1, fire_0, fire_1, drop_0, drop_1, casc1_on} = '0;
      instr_boundary = 1'b1;
      n_mismatch = 0;
      n_tests = 0;
      n_take = 0;
      rst = 1'b1;
      tick(8);
      rst <= 1'b0;
      t_reset;
      t_priority;
      t_level;
      t_nmi;
      t_cascade;
      t_slave;
      t_demod;
      tally_and_finish;
   end
endmodule
bind eint_front eint_front_checker eint_front_checker_inst (.*);
